/* core/lts_pkg.sv */
// constants, offsets and state types for the logic timer block
// assumes a 10 MHz pclk and an APB master with 32-bit data
package lts_pkg;

	// time base
	localparam int CLK_PERIOD_NS  = 100;
	localparam int TENTH_MS       = 100;
	localparam int FAST_PERIOD_MS = 100;
	localparam int SLOW_PERIOD_MS = 1000;
	localparam int NS_PER_MS      = 1000000;
	localparam int TICK_CYCLES_DEF      = TENTH_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int FAST_HALF_CYCLES_DEF = FAST_PERIOD_MS * NS_PER_MS / 2 / CLK_PERIOD_NS;
	localparam int SLOW_RATIO           = SLOW_PERIOD_MS / FAST_PERIOD_MS;
	localparam int SLOW_CNT_W           = 4;
	localparam int SUB_W_DEF            = 20;

	// settings in tenths of a second
	localparam int                SET_W     = 13;
	localparam logic [SET_W-1:0]  SET_MAX   = 13'h1770;
	localparam logic [SET_W-1:0]  SET_RESET = 13'h0000;
	localparam int                NUM_SET   = 6;

	// setting indices
	localparam int IDX_DELAY_SETTING_ONE     = 0;
	localparam int IDX_PULSE_WIDTH_SETTING   = 3;
	localparam int IDX_CYCLE_OFF_TIME_SETTING = 4;
	localparam int IDX_CYCLE_ON_TIME_SETTING  = 5;

	// timer units: three on-delay, one-shot, interval
	localparam int NUM_ODLY  = 3;
	localparam int NUM_UNITS = 5;
	localparam int U_PULSE   = 3;
	localparam int U_CYCLE   = 4;

	// register map
	localparam int                ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFS_SETTING [NUM_SET] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014};
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h018;

	// status layout
	localparam int SHIFT_N = 4;
	localparam int ST_W    = 11;

	typedef enum logic
	{
		OS_IDLE  = 1'b0,
		OS_PULSE = 1'b1
	} lts_os_state_e;

	typedef enum logic [1:0]
	{
		IV_IDLE = 2'b00,
		IV_OFF  = 2'b01,
		IV_ON   = 2'b10
	} lts_iv_state_e;

endpackage

/* core/lts_logic_timers.sv */
// logic timers, one-shot, interval timer, square waves and 4-stage shift register
// assumes timer inputs come from logic on pclk; settings written over APB
`timescale 1ns/100ps
`default_nettype none

module lts_logic_timers #(
	parameter int TICK_CYCLES      = lts_pkg::TICK_CYCLES_DEF,
	parameter int FAST_HALF_CYCLES = lts_pkg::FAST_HALF_CYCLES_DEF,
	parameter int SUB_W            = lts_pkg::SUB_W_DEF
)(
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         ce,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [lts_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic [lts_pkg::NUM_ODLY-1:0] on_delay_timer_in,
	output logic      [lts_pkg::NUM_ODLY-1:0] on_delay_timer_out,
	input  wire logic                         one_shot_in,
	output logic                              one_shot_out,
	input  wire logic                         cyclic_interval_timer_in,
	output logic                              cyclic_interval_timer_out,
	output logic                              fast_square_wave,
	output logic                              slow_square_wave,
	input  wire logic                         shift_data,
	input  wire logic                         shift_clk,
	input  wire logic                         shift_reset,
	output logic      [lts_pkg::SHIFT_N-1:0]  shift_bits
);

	logic [lts_pkg::SET_W-1:0]      setting [lts_pkg::NUM_SET];
	logic [31:0]                    next_rdata;
	logic                           next_err;
	logic [lts_pkg::ST_W-1:0]       status;
	logic                           apb_setup;
	logic                           apb_write;
	logic [SUB_W-1:0]               sub_cnt [lts_pkg::NUM_UNITS];
	logic [lts_pkg::SET_W-1:0]      tenth_cnt [lts_pkg::NUM_UNITS];
	logic [lts_pkg::SET_W-1:0]      target [lts_pkg::NUM_UNITS];
	logic [lts_pkg::NUM_UNITS-1:0]  restart;
	logic [lts_pkg::NUM_UNITS-1:0]  expired;
	logic [lts_pkg::NUM_UNITS-1:0]  ending;
	lts_pkg::lts_os_state_e         os_state;
	logic                           os_prev;
	logic                           os_rise;
	lts_pkg::lts_iv_state_e         iv_state;
	logic [SUB_W-1:0]               half_cnt;
	logic [lts_pkg::SLOW_CNT_W-1:0] slow_cnt;
	logic                           sclk_prev;
	logic                           sclk_rise;

	localparam logic [SUB_W-1:0] SUB_LAST  = SUB_W'(TICK_CYCLES - 1);
	localparam logic [SUB_W-1:0] HALF_LAST = SUB_W'(FAST_HALF_CYCLES - 1);
	localparam logic [lts_pkg::SLOW_CNT_W-1:0] SLOW_LAST = lts_pkg::SLOW_CNT_W'(lts_pkg::SLOW_RATIO - 1);

	// apb slave
	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pready & pwrite;
	assign status    = {shift_bits, slow_square_wave, fast_square_wave,
		cyclic_interval_timer_out, one_shot_out, on_delay_timer_out};

	always_comb
	begin
		next_rdata = '0;
		next_err   = 1'b1;
		if (paddr == lts_pkg::OFS_STATUS)
		begin
			next_rdata = 32'(status);
			next_err   = 1'b0;
		end
		for (int i = 0; i < lts_pkg::NUM_SET; i++)
		begin
			if (paddr == lts_pkg::OFS_SETTING[i])
			begin
				next_rdata = 32'(setting[i]);
				next_err   = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else if (ce)
		begin
			pready <= apb_setup;
			if (apb_setup)
			begin
				prdata  <= next_rdata;
				pslverr <= next_err;
			end
		end
	end

	// settings, clamped to the 600.0 s ceiling
	genvar gs;
	generate
		for (gs = 0; gs < lts_pkg::NUM_SET; gs++)
		begin : g_set
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					setting[gs] <= lts_pkg::SET_RESET;
				else if (ce && apb_write && paddr == lts_pkg::OFS_SETTING[gs])
					setting[gs] <= (pwdata > 32'(lts_pkg::SET_MAX)) ? lts_pkg::SET_MAX :
						pwdata[lts_pkg::SET_W-1:0];
			end
		end
	endgenerate

	// per-unit tenth-second counters
	always_comb
	begin
		for (int i = 0; i < lts_pkg::NUM_ODLY; i++)
		begin
			target[i]  = setting[lts_pkg::IDX_DELAY_SETTING_ONE + i];
			restart[i] = ~on_delay_timer_in[i];
		end
		target[lts_pkg::U_PULSE]  = setting[lts_pkg::IDX_PULSE_WIDTH_SETTING];
		restart[lts_pkg::U_PULSE] = (os_state == lts_pkg::OS_IDLE);
		target[lts_pkg::U_CYCLE]  = (iv_state == lts_pkg::IV_ON) ?
			setting[lts_pkg::IDX_CYCLE_ON_TIME_SETTING] : setting[lts_pkg::IDX_CYCLE_OFF_TIME_SETTING];
		restart[lts_pkg::U_CYCLE] = (iv_state == lts_pkg::IV_IDLE) | ending[lts_pkg::U_CYCLE];
	end

	genvar gu;
	generate
		for (gu = 0; gu < lts_pkg::NUM_UNITS; gu++)
		begin : g_unit
			assign expired[gu] = (tenth_cnt[gu] >= target[gu]);
			assign ending[gu]  = expired[gu] |
				((tenth_cnt[gu] == target[gu] - lts_pkg::SET_W'(1)) && (sub_cnt[gu] == SUB_LAST));

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					sub_cnt[gu]   <= '0;
					tenth_cnt[gu] <= '0;
				end
				else if (ce)
				begin
					if (restart[gu])
					begin
						sub_cnt[gu]   <= '0;
						tenth_cnt[gu] <= '0;
					end
					else if (!expired[gu])
					begin
						if (sub_cnt[gu] == SUB_LAST)
						begin
							sub_cnt[gu]   <= '0;
							tenth_cnt[gu] <= tenth_cnt[gu] + lts_pkg::SET_W'(1);
						end
						else
							sub_cnt[gu] <= sub_cnt[gu] + SUB_W'(1);
					end
				end
			end
		end
	endgenerate

	// on-delay outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			on_delay_timer_out <= '0;
		else if (ce)
			on_delay_timer_out <= on_delay_timer_in & expired[lts_pkg::NUM_ODLY-1:0];
	end

	// one-shot
	assign os_rise = one_shot_in & ~os_prev;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			os_prev      <= 1'b0;
			os_state     <= lts_pkg::OS_IDLE;
			one_shot_out <= 1'b0;
		end
		else if (ce)
		begin
			os_prev <= one_shot_in;
			case (os_state)
				lts_pkg::OS_IDLE:
				begin
					if (os_rise && setting[lts_pkg::IDX_PULSE_WIDTH_SETTING] != lts_pkg::SET_RESET)
					begin
						os_state     <= lts_pkg::OS_PULSE;
						one_shot_out <= 1'b1;
					end
				end
				lts_pkg::OS_PULSE:
				begin
					if (ending[lts_pkg::U_PULSE])
					begin
						os_state     <= lts_pkg::OS_IDLE;
						one_shot_out <= 1'b0;
					end
				end
				default:
				begin
					os_state     <= lts_pkg::OS_IDLE;
					one_shot_out <= 1'b0;
				end
			endcase
		end
	end

	// interval timer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			iv_state                  <= lts_pkg::IV_IDLE;
			cyclic_interval_timer_out <= 1'b0;
		end
		else if (ce)
		begin
			case (iv_state)
				lts_pkg::IV_IDLE:
				begin
					cyclic_interval_timer_out <= 1'b0;
					if (cyclic_interval_timer_in)
						iv_state <= lts_pkg::IV_OFF;
				end
				lts_pkg::IV_OFF:
				begin
					if (ending[lts_pkg::U_CYCLE])
					begin
						iv_state                  <= lts_pkg::IV_ON;
						cyclic_interval_timer_out <=
							(setting[lts_pkg::IDX_CYCLE_ON_TIME_SETTING] != lts_pkg::SET_RESET);
					end
				end
				lts_pkg::IV_ON:
				begin
					if (ending[lts_pkg::U_CYCLE])
					begin
						cyclic_interval_timer_out <= 1'b0;
						iv_state <= cyclic_interval_timer_in ? lts_pkg::IV_OFF : lts_pkg::IV_IDLE;
					end
				end
				default:
				begin
					iv_state                  <= lts_pkg::IV_IDLE;
					cyclic_interval_timer_out <= 1'b0;
				end
			endcase
		end
	end

	// free-running square waves
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			half_cnt         <= '0;
			slow_cnt         <= '0;
			fast_square_wave <= 1'b0;
			slow_square_wave <= 1'b0;
		end
		else if (ce)
		begin
			if (half_cnt == HALF_LAST)
			begin
				half_cnt         <= '0;
				fast_square_wave <= ~fast_square_wave;
				if (slow_cnt == SLOW_LAST)
				begin
					slow_cnt         <= '0;
					slow_square_wave <= ~slow_square_wave;
				end
				else
					slow_cnt <= slow_cnt + lts_pkg::SLOW_CNT_W'(1);
			end
			else
				half_cnt <= half_cnt + SUB_W'(1);
		end
	end

	// shift register
	assign sclk_rise = shift_clk & ~sclk_prev;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sclk_prev <= 1'b0;
		else if (ce)
			sclk_prev <= shift_clk;
	end

	always_ff @(posedge pclk or negedge presetn or posedge shift_reset)
	begin
		if (!presetn)
			shift_bits <= '0;
		else if (shift_reset)
			shift_bits <= '0;
		else if (ce && sclk_rise)
			shift_bits <= {shift_bits[lts_pkg::SHIFT_N-2:0], shift_data};
	end

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_ODLY_EARLY: assert property (ce && on_delay_timer_in[0] && !expired[0] |=> !on_delay_timer_out[0])
		else $error("on-delay output rose before its delay");
	AST_ODLY_DROP: assert property (ce && !on_delay_timer_in[1] |=> !on_delay_timer_out[1] && tenth_cnt[1] == '0)
		else $error("on-delay output or count did not clear");
	AST_ODLY_ZERO: assert property (ce && on_delay_timer_in[1] &&
		setting[lts_pkg::IDX_DELAY_SETTING_ONE + 1] == lts_pkg::SET_RESET |=> on_delay_timer_out[1])
		else $error("zero delay did not act at once");
	AST_OS_START: assert property (ce && os_state == lts_pkg::OS_IDLE && os_rise &&
		setting[lts_pkg::IDX_PULSE_WIDTH_SETTING] != lts_pkg::SET_RESET |=> one_shot_out)
		else $error("one-shot did not start on a rise");
	AST_OS_HOLD: assert property (ce && os_state == lts_pkg::OS_PULSE && !ending[lts_pkg::U_PULSE]
		|=> one_shot_out && os_state == lts_pkg::OS_PULSE)
		else $error("one-shot pulse cut short");
	AST_IV_OFF_LOW: assert property (iv_state == lts_pkg::IV_OFF |-> !cyclic_interval_timer_out)
		else $error("interval output high in off-time");
	AST_IV_REPEAT: assert property (ce && iv_state == lts_pkg::IV_ON && ending[lts_pkg::U_CYCLE] &&
		cyclic_interval_timer_in |=> iv_state == lts_pkg::IV_OFF && !cyclic_interval_timer_out)
		else $error("interval cycle did not repeat");
	AST_IV_FINISH: assert property (ce && iv_state == lts_pkg::IV_OFF && !ending[lts_pkg::U_CYCLE]
		|=> iv_state == lts_pkg::IV_OFF)
		else $error("interval off-time abandoned");
	AST_FAST_WAVE: assert property ($changed(fast_square_wave) |-> $past(half_cnt) == HALF_LAST)
		else $error("fast wave toggled off schedule");
	AST_SR_SHIFT: assert property (ce && !shift_reset && sclk_rise |=> shift_reset ||
		shift_bits == {$past(shift_bits[lts_pkg::SHIFT_N-2:0]), $past(shift_data)})
		else $error("shift register did not shift");
	AST_SR_HOLD: assert property (!sclk_rise && !shift_reset |=> shift_reset || $stable(shift_bits))
		else $error("shift stages changed without an edge");
	AST_SR_CLEAR: assert property (shift_reset && $past(shift_reset) |-> shift_bits == '0)
		else $error("shift reset did not clear stages");

	COV_ODLY_FIRE: cover property ($rose(on_delay_timer_out[0]));
	COV_OS_PULSE: cover property ($fell(one_shot_out));
	COV_IV_REPEAT: cover property (iv_state == lts_pkg::IV_ON ##1 iv_state == lts_pkg::IV_OFF);
	COV_SR_SHIFT: cover property (ce && sclk_rise && shift_data && !shift_reset);

endmodule

`default_nettype wire

/* sim/lts_shift_partner.sv */
// shift stimulus source standing in for the program logic
// assumes pclk from the bench; levels change just after rising edges
`timescale 1ns/100ps
`default_nettype none
module lts_shift_partner (
	input  wire logic pclk,
	output logic      shift_data,
	output logic      shift_clk
);
	initial
	begin
		shift_data = 1'b0;
		shift_clk  = 1'b0;
	end

	// one rising shift clock held high n+1 cycles, data wobbling meanwhile
	task automatic push(input logic b, input int n);
		@(posedge pclk);
		shift_clk  <= 1'b0;
		shift_data <= b;
		@(posedge pclk);
		shift_clk <= 1'b1;
		repeat (n)
		begin
			@(posedge pclk);
			shift_data <= ~shift_data;
		end
		@(posedge pclk);
		shift_clk  <= 1'b0;
		shift_data <= ~b;
	endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the logic timer block
// assumes a short tick of 10 cycles and a fast half period of 5
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int T = 10;
	logic                        pclk;
	logic                        presetn;
	logic                        ce;
	logic                        psel;
	logic                        penable;
	logic                        pwrite;
	logic [lts_pkg::ADDR_W-1:0]  paddr;
	logic [31:0]                 pwdata;
	logic [31:0]                 prdata;
	logic                        pready;
	logic                        pslverr;
	logic [2:0]                  od_in;
	logic [2:0]                  od_out;
	logic                        os_in;
	logic                        os_out;
	logic                        iv_in;
	logic                        iv_out;
	logic                        fast;
	logic                        slow;
	logic                        sh_data;
	logic                        sh_clk;
	logic                        sh_rst;
	logic [3:0]                  sh_bits;
	logic [31:0]                 q;
	logic                        e;
	logic [3:0]                  x4;
	logic                        pf;
	logic                        ps;
	int                          error_cnt;
	int                          n_checks;
	int                          cyc;
	int                          c1, c2, c3, cos, civ, cft, cst, cfh, a, b, d;

	lts_logic_timers #(.TICK_CYCLES(T), .FAST_HALF_CYCLES(5), .SUB_W(lts_pkg::SUB_W_DEF)) u_lts_logic_timers (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.on_delay_timer_in(od_in), .on_delay_timer_out(od_out), .one_shot_in(os_in), .one_shot_out(os_out),
		.cyclic_interval_timer_in(iv_in), .cyclic_interval_timer_out(iv_out),
		.fast_square_wave(fast), .slow_square_wave(slow), .shift_data(sh_data), .shift_clk(sh_clk),
		.shift_reset(sh_rst), .shift_bits(sh_bits)
	);

	lts_shift_partner u_lts_shift_partner (.pclk(pclk), .shift_data(sh_data), .shift_clk(sh_clk));

	initial pclk = 1'b0;
	always #50 pclk = ~pclk;

	// output activity counters, sampled mid-cycle
	always @(negedge pclk)
	begin
		c1  += od_out[0];
		c2  += od_out[1];
		c3  += od_out[2];
		cos += os_out;
		civ += iv_out;
		cfh += fast;
		cft += (fast != pf);
		cst += (slow != ps);
		pf = fast;
		ps = slow;
		cyc++;
		if (cyc == 4000)
		begin
			error_cnt++;
			summarize();
		end
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x)
		begin
			error_cnt++;
			$display("[ERR] %s exp=%h seen=%h", nm, x, s);
		end
	endtask

	task automatic cy(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// one apb transfer; read data and error land in q and e
	task automatic apb(input logic w, input logic [lts_pkg::ADDR_W-1:0] ad, input logic [31:0] dt);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= dt;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		chk("pready_wait", n, 32'h1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic summarize();
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		presetn = 1'b0;
		ce      = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = '0;
		pwdata  = '0;
		od_in   = 3'h0;
		os_in   = 1'b0;
		iv_in   = 1'b0;
		sh_rst  = 1'b0;
		cy(20);
		presetn <= 1'b1;
		for (int i = 0; i < lts_pkg::NUM_SET; i++)
		begin
			apb(1'b0, lts_pkg::OFS_SETTING[i], 32'h0);
			chk("setting_default", q, 32'h0);
		end
		apb(1'b0, 12'h01c, 32'h0);
		chk("unmapped_err", {31'h0, e}, 32'h1);
		apb(1'b1, lts_pkg::OFS_SETTING[2], 32'h1fff);
		apb(1'b0, lts_pkg::OFS_SETTING[2], 32'h0);
		chk("setting_clamp", q, {19'h0, lts_pkg::SET_MAX});
		apb(1'b1, lts_pkg::OFS_SETTING[2], 32'h1);
		apb(1'b1, lts_pkg::OFS_SETTING[0], 32'h2);
		apb(1'b1, lts_pkg::OFS_SETTING[1], 32'h0);
		apb(1'b1, lts_pkg::OFS_SETTING[3], 32'h3);
		apb(1'b1, lts_pkg::OFS_SETTING[4], 32'h2);
		apb(1'b1, lts_pkg::OFS_SETTING[5], 32'h1);
		$display("test registers done");
		// short hold must not fire, then a full hold
		a = c1;
		od_in <= 3'b001;
		cy(15);
		od_in <= 3'b000;
		cy(5);
		od_in <= 3'b001;
		cy(40);
		od_in <= 3'b000;
		cy(5);
		chk("delay_high", c1 - a, 40 - 2 * T);
		a = c2;
		od_in <= 3'b010;
		cy(10);
		od_in <= 3'b000;
		cy(3);
		chk("zero_delay_high", c2 - a, 10);
		a = c3;
		od_in <= 3'b100;
		cy(30);
		od_in <= 3'b000;
		cy(3);
		chk("delay3_high", c3 - a, 30 - T);
		$display("test on-delay done");
		a = cos;
		os_in <= 1'b1;
		cy(10);
		os_in <= 1'b0;
		cy(5);
		os_in <= 1'b1;
		cy(35);
		os_in <= 1'b0;
		cy(20);
		chk("pulse_once", cos - a, 3 * T);
		os_in <= 1'b1;
		cy(40);
		os_in <= 1'b0;
		cy(2);
		chk("pulse_again", cos - a, 6 * T);
		$display("test one-shot done");
		a = civ;
		iv_in <= 1'b1;
		cy(1);
		iv_in <= 1'b0;
		cy(15);
		chk("off_first", civ - a, 0);
		cy(45);
		chk("cycle_single", civ - a, T);
		a = civ;
		iv_in <= 1'b1;
		cy(45);
		iv_in <= 1'b0;
		cy(60);
		chk("cycle_repeat", civ - a, 2 * T);
		$display("test interval done");
		a = cft;
		b = cst;
		d = cfh;
		cy(200);
		chk("fast_toggles", cft - a, 40);
		chk("slow_toggles", cst - b, 4);
		chk("fast_duty", cfh - d, 100);
		ce <= 1'b0;
		cy(1);
		a = cft;
		cy(20);
		chk("ce_freeze", cft - a, 0);
		ce <= 1'b1;
		$display("test square waves done");
		x4 = 4'h0;
		for (int i = 0; i < 4; i++)
		begin
			u_lts_shift_partner.push(1'(4'b1101 >> i), 1);
			x4 = {x4[2:0], 1'(4'b1101 >> i)};
			cy(1);
			chk("shift_stage", sh_bits, x4);
		end
		u_lts_shift_partner.push(1'b0, 4);
		x4 = {x4[2:0], 1'b0};
		chk("shift_hold", sh_bits, x4);
		apb(1'b0, lts_pkg::OFS_STATUS, 32'h0);
		chk("status_shift", {28'h0, q[10:7]}, {28'h0, x4});
		@(posedge pclk);
		sh_rst <= 1'b1;
		#10;
		chk("shift_clear", sh_bits, 32'h0);
		u_lts_shift_partner.push(1'b1, 1);
		chk("shift_blocked", sh_bits, 32'h0);
		sh_rst <= 1'b0;
		$display("test shift register done");
		summarize();
	end
endmodule
`default_nettype wire
